// file: hdl/trs_sequencer.sv
// Functional notes
// - single mode plays one pass per trigger
// - single mode drops triggers during a pass
// - burst plays programmed number of passes
// - burst count holds up to 4096
// - burst ignores triggers until passes done
// - gated starts on gate active edge
// - gated stops at end of current pass
// - delay steps by one sample clock
// - fixed five-clock pipeline even at zero delay
// - minimum latency constant for a given rate
// - triggers from pushbutton, external pin or host
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
module trs_sequencer (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire logic button_pin,
   input wire logic ext_trig_pin,
   input wire logic pass_done,
   output trs_pkg::trs_play_t play
);

   trs_pkg::trs_ctrl_t ctrl_q; // Mode, polarity, run
   logic [12:0] burst_q; // Passes per burst trigger
   logic [31:0] delay_q; // Trigger delay in sample clocks
   logic miss_q; // A trigger was ignored, sticky
   logic host_trig_q; // Trigger from a remote command
   logic [12:0] left_q; // Passes still to play
   logic start_q; // Pass start pulse
   logic [31:0] rdata_q; // Read data, one cycle after strobe
   trs_pkg::trs_state_t st_q; // Sequencer state
   trs_pkg::trs_state_t st_d;

   // Write decode
   wire wr_ctrl = wr && (addr == trs_pkg::TRS_OFF_CTRL);
   wire wr_burst = wr && (addr == trs_pkg::TRS_OFF_BURST);
   wire wr_delay = wr && (addr == trs_pkg::TRS_OFF_DELAY);
   wire wr_status = wr && (addr == trs_pkg::TRS_OFF_STATUS);
   wire wr_cmd = wr && (addr == trs_pkg::TRS_OFF_CMD);

   // Pin conditioning: bit 0 button, bit 1 external trigger
   logic [1:0] pin_lvl;
   logic [1:0] pin_rise;
   logic [1:0] pin_fall;

   trs_pin_sync #(
      .W(2)
   ) u_sync (
      .clk(clk),
      .resetn(resetn),
      .pin({ext_trig_pin, button_pin}),
      .level(pin_lvl),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Mode selection
   wire mode_cont = ctrl_q.mode == trs_pkg::TRS_MODE_CONT;
   wire mode_single = ctrl_q.mode == trs_pkg::TRS_MODE_SINGLE;
   wire mode_burst = ctrl_q.mode == trs_pkg::TRS_MODE_BURST;
   wire mode_gated = ctrl_q.mode == trs_pkg::TRS_MODE_GATED;

   // External edge per polarity; negative polarity uses falling edge
   wire ext_edge = ctrl_q.pol ? pin_fall[1] : pin_rise[1];
   // Gate level, active per the same polarity
   wire gate_act = pin_lvl[1] ^ ctrl_q.pol;

   wire trig_any = pin_rise[0] || ext_edge || host_trig_q;
   // in gated mode only the gate active edge starts
   wire trig_in = mode_gated ? ext_edge : trig_any;
   // Continuous mode never uses triggers
   wire trig_used = ctrl_q.run && !mode_cont && trig_in;
   wire in_idle = st_q == trs_pkg::TRS_IDLE;
   wire in_wait = st_q == trs_pkg::TRS_WAIT;
   wire in_play = st_q == trs_pkg::TRS_PLAY;
   wire trig_acc = trig_used && in_idle;
   // triggers while busy are dropped, only flagged
   wire trig_drop = trig_used && !in_idle;

   // End of a pass and the decision to play another
   wire pass_end = in_play && pass_done && ctrl_q.run;
   wire more_burst = mode_burst && (left_q > 13'h0001);
   // gated repeats only while the gate is still active
   wire more_gate = mode_gated && gate_act;
   wire again = mode_cont || more_burst || more_gate;

   // Delay counter and fixed pipeline
   logic dly_busy;
   logic dly_fire;
   wire dly_clear = !ctrl_q.run;

   trs_delay #(
      .PIPE(trs_pkg::TRS_PIPE_CLKS)
   ) u_delay (
      .clk(clk),
      .resetn(resetn),
      .load(trig_acc),
      .clear(dly_clear),
      .value(delay_q),
      .busy(dly_busy),
      .fire(dly_fire)
   );

   // Burst clamp: zero becomes one, above the limit becomes the limit
   wire burst_big = wdata > {19'h00000, trs_pkg::TRS_BURST_MAX};
   wire burst_zero = wdata == 32'h0000_0000;
   wire [12:0] burst_wr = burst_big ? trs_pkg::TRS_BURST_MAX :
      burst_zero ? 13'h0001 : wdata[12:0];

   // Software registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= '0;
         burst_q <= trs_pkg::TRS_BURST_RST;
         delay_q <= trs_pkg::TRS_DELAY_RST;
         host_trig_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= wdata[trs_pkg::TRS_CTRL_RUN_BIT:0];
         end
         if (wr_burst) begin
            burst_q <= burst_wr;
         end
         if (wr_delay) begin
            delay_q <= wdata;
         end
         host_trig_q <= wr_cmd && wdata[trs_pkg::TRS_CMD_TRIG_BIT];
      end
   end

   // Sticky miss flag; a new drop beats a clear in the same cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         miss_q <= 1'b0;
      end else if (trig_drop) begin
         miss_q <= 1'b1;
      end else if (wr_status && wdata[trs_pkg::TRS_ST_MISS_BIT]) begin
         miss_q <= 1'b0;
      end
   end

   // Next state
   always_comb begin
      st_d = st_q;
      case (st_q)
         trs_pkg::TRS_IDLE: begin
            if (ctrl_q.run && mode_cont) begin
               st_d = trs_pkg::TRS_PLAY;
            end else if (trig_acc) begin
               st_d = trs_pkg::TRS_WAIT;
            end
         end
         trs_pkg::TRS_WAIT: begin
            if (!ctrl_q.run) begin
               st_d = trs_pkg::TRS_IDLE;
            end else if (dly_fire) begin
               st_d = trs_pkg::TRS_PLAY;
            end
         end
         trs_pkg::TRS_PLAY: begin
            if (!ctrl_q.run) begin
               st_d = trs_pkg::TRS_IDLE;
            end else if (pass_end && !again) begin
               // single mode halts after one pass
               st_d = trs_pkg::TRS_IDLE;
            end
         end
         default: begin
            st_d = trs_pkg::TRS_IDLE;
         end
      endcase
   end

   // State, pass counter and start pulse
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= trs_pkg::TRS_IDLE;
         left_q <= 13'h0000;
         start_q <= 1'b0;
      end else begin
         st_q <= st_d;
         start_q <= 1'b0;
         if (in_idle && ctrl_q.run && mode_cont) begin
            start_q <= 1'b1;
         end else if (in_wait && ctrl_q.run && dly_fire) begin
            left_q <= mode_burst ? burst_q : 13'h0001;
            start_q <= 1'b1;
         end else if (pass_end && again) begin
            // only the pass counter or a write to the control register ends a burst
            if (mode_burst) begin
               left_q <= left_q - 13'h0001;
            end
            start_q <= 1'b1;
         end else if (pass_end) begin
            left_q <= 13'h0000;
         end
      end
   end

   // Read mux; unmapped and write-only offsets read zero
   wire [31:0] st_word = {3'h0, left_q, 13'h0000, miss_q, in_wait,
      in_play};
   wire [31:0] rd_mux =
      (addr == trs_pkg::TRS_OFF_CTRL) ? {28'h0000000, ctrl_q} :
      (addr == trs_pkg::TRS_OFF_BURST) ? {19'h00000, burst_q} :
      (addr == trs_pkg::TRS_OFF_DELAY) ? delay_q :
      (addr == trs_pkg::TRS_OFF_STATUS) ? st_word : 32'h0000_0000;

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rd ? rd_mux : 32'h0000_0000;
      end
   end

   assign rdata = rdata_q;
   assign play.start = start_q;
   assign play.active = in_play;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_pass_end;
      in_play && pass_done && ctrl_q.run;
   endsequence

   a_cont_repeat: assert property (
      s_pass_end and mode_cont |=> start_q && in_play)
      else $error("continuous did not restart");

   a_single_halt: assert property (
      s_pass_end and mode_single |=> in_idle && !start_q)
      else $error("single did not halt");

   a_single_drop: assert property (
      mode_single && in_play && trig_used && !pass_done |=>
      !in_wait ##1 miss_q)
      else $error("busy trigger not dropped");

   a_burst_count: assert property (
      s_pass_end and more_burst |=>
      start_q && left_q == $past(left_q) - 13'h0001)
      else $error("burst count step wrong");

   a_burst_limit: assert property (
      burst_q <= trs_pkg::TRS_BURST_MAX && burst_q != 13'h0000)
      else $error("burst count out of range");

   a_burst_ignore: assert property (
      mode_burst && in_play && trig_used && !pass_done |=>
      $stable(left_q) && in_play)
      else $error("burst disturbed by trigger");

   a_gate_start: assert property (
      mode_gated && in_idle && ctrl_q.run && ext_edge |=> in_wait)
      else $error("gate edge did not arm");

   a_gate_stop: assert property (
      s_pass_end and mode_gated and !gate_act |=> in_idle)
      else $error("gated did not stop at pass end");

   a_fire_start: assert property (
      in_wait && ctrl_q.run && dly_fire |=> start_q && in_play)
      else $error("pipeline did not start pass");

   a_host_trig: assert property (
      host_trig_q && ctrl_q.run && mode_single && in_idle |=> in_wait)
      else $error("host trigger not taken");

   a_delay_busy: assert property (
      in_wait && ctrl_q.run && !dly_fire |-> dly_busy)
      else $error("waiting without delay running");

   a_miss_sticky: assert property (
      trig_drop |=> miss_q)
      else $error("dropped trigger not flagged");

   a_run_abort: assert property (
      !ctrl_q.run && !in_idle |=> in_idle && !start_q)
      else $error("clearing run did not stop playback");

   a_gate_more: assert property (
      s_pass_end and mode_gated and gate_act |=> start_q && in_play)
      else $error("gated stopped while gate active");

   a_burst_end: assert property (
      s_pass_end and mode_burst and left_q == 13'h0001 |=> in_idle)
      else $error("burst played too many passes");

endmodule

// file: hdl/trs_pkg.sv
package trs_pkg;

   // Register byte offsets
   localparam logic [7:0] TRS_OFF_CTRL = 8'h00;
   localparam logic [7:0] TRS_OFF_BURST = 8'h04;
   localparam logic [7:0] TRS_OFF_DELAY = 8'h08;
   localparam logic [7:0] TRS_OFF_STATUS = 8'h0C;
   localparam logic [7:0] TRS_OFF_CMD = 8'h10;

   // Control field positions
   localparam int TRS_CTRL_MODE_LSB = 0;
   localparam int TRS_CTRL_POL_BIT = 2;
   localparam int TRS_CTRL_RUN_BIT = 3;

   // Status field positions
   localparam int TRS_ST_PLAY_BIT = 0;
   localparam int TRS_ST_WAIT_BIT = 1;
   localparam int TRS_ST_MISS_BIT = 2;
   localparam int TRS_ST_LEFT_LSB = 16;

   // Command field positions
   localparam int TRS_CMD_TRIG_BIT = 0;

   // Mode encodings in the control register
   localparam logic [1:0] TRS_MODE_CONT = 2'h0;
   localparam logic [1:0] TRS_MODE_SINGLE = 2'h1;
   localparam logic [1:0] TRS_MODE_BURST = 2'h2;
   localparam logic [1:0] TRS_MODE_GATED = 2'h3;

   // Burst limits and reset values
   localparam int TRS_BURST_W = 13;
   localparam logic [12:0] TRS_BURST_MAX = 13'h1000;
   localparam logic [12:0] TRS_BURST_RST = 13'h0001;
   localparam logic [31:0] TRS_DELAY_RST = 32'h0000_0000;

   // Trigger path timing
   localparam int TRS_PIPE_CLKS = 5;
   // Analog part of the latency; outside this logic, kept for software
   localparam int TRS_FIXED_NS = 35;
   localparam int TRS_SYNC_FF = 3;

   // Software control word
   typedef struct packed {
      logic run;
      logic pol;
      logic [1:0] mode;
   } trs_ctrl_t;

   // Playback handshake towards the waveform engine
   typedef struct packed {
      logic start;
      logic active;
   } trs_play_t;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      TRS_IDLE = 3'h1,
      TRS_WAIT = 3'h2,
      TRS_PLAY = 3'h4
   } trs_state_t;

endpackage

// file: hdl/trs_pin_sync.sv
`timescale 1ns/1ps
module trs_pin_sync #(
   parameter int W = 2
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [W-1:0] pin,
   output logic [W-1:0] level,
   output logic [W-1:0] rise,
   output logic [W-1:0] fall
);

   // Three stages per pin; a change counts once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         logic s1_q;
         logic s2_q;
         logic s3_q;
         logic lvl_q;
         logic rise_q;
         logic fall_q;
         wire agree = (s2_q == s3_q);
         wire change = agree && (s3_q != lvl_q);

         // Stage one is read only by stage two
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               s1_q <= 1'b0;
               s2_q <= 1'b0;
               s3_q <= 1'b0;
            end else begin
               s1_q <= pin[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
            end
         end

         // Filtered level and its edges, one-cycle pulses
         always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
               lvl_q <= 1'b0;
               rise_q <= 1'b0;
               fall_q <= 1'b0;
            end else begin
               if (change) begin
                  lvl_q <= s3_q;
               end
               rise_q <= change && s3_q;
               fall_q <= change && !s3_q;
            end
         end

         assign level[i] = lvl_q;
         assign rise[i] = rise_q;
         assign fall[i] = fall_q;
      end
   endgenerate

endmodule

// file: hdl/trs_delay.sv
`timescale 1ns/1ps
module trs_delay #(
   parameter int PIPE = trs_pkg::TRS_PIPE_CLKS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic load,
   input wire logic clear,
   input wire logic [31:0] value,
   output logic busy,
   output logic fire
);

   logic [31:0] cnt_q; // Remaining sample clocks
   logic busy_q; // Counting down
   logic [PIPE-1:0] pipe_q; // Fixed pipeline, never bypassed
   wire expire = busy_q && (cnt_q == 32'h0000_0000);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 32'h0000_0000;
         busy_q <= 1'b0;
      end else if (clear) begin
         busy_q <= 1'b0;
      end else if (load) begin
         cnt_q <= value;
         busy_q <= 1'b1;
      end else if (expire) begin
         busy_q <= 1'b0;
      end else if (busy_q) begin
         cnt_q <= cnt_q - 32'h0000_0001;
      end
   end

   // same length on every trigger, so latency is constant
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pipe_q <= '0;
      end else if (clear) begin
         pipe_q <= '0;
      end else begin
         pipe_q <= {pipe_q[PIPE-2:0], expire};
      end
   end

   assign busy = busy_q || (pipe_q != '0);
   assign fire = pipe_q[PIPE-1];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_zero_load;
      load && !clear && (value == 32'h0000_0000);
   endsequence

   a_zero_delay_lat: assert property (
      s_zero_load ##1 (!clear) [*6] |-> fire)
      else $error("zero delay latency wrong");

   a_fire_not_early: assert property (
      s_zero_load |-> ##1 !fire [*5])
      else $error("fire came too early");

endmodule

// file: tb/trs_engine_model.sv
`timescale 1ns/1ps
// Waveform engine stand-in: a pass lasts LEN sample clocks
module trs_engine_model #(
   parameter int LEN = 12
) (
   input wire logic clk,
   input wire logic resetn,
   input wire trs_pkg::trs_play_t play,
   output logic pass_done
);
   int left_q; // Clocks left in the current pass
   // Count the pass down; a fresh start reloads it
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         left_q <= 0;
         pass_done <= 1'b0;
      end else begin
         // One-cycle end-of-pass pulse
         pass_done <= (left_q == 1);
         if (play.start === 1'b1) begin
            left_q <= LEN;
         end else if (left_q > 0) begin
            left_q <= left_q - 1;
         end
      end
   end
endmodule

// file: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   n_checks++; \
   if ((g) !== (e)) begin \
      fails++; \
      $display("[ERR] %s exp=%0h got=%0h", nm, e, g); \
   end \
end
module tb_top;
   localparam int LEN = 12; // Pass length of the engine
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic button_pin = 1'b0;
   logic ext_trig_pin = 1'b0;
   logic pass_done;
   trs_pkg::trs_play_t play;
   int fails = 0;
   int n_checks = 0;
   int n_start = 0; // Starts seen since last clear
   logic [31:0] rv;
   int k, d, n;
   // Burst values: zero, maximum, above maximum, random legal
   logic [31:0] d_tab [4] = '{32'h0000_0000, 32'h0000_1000,
      32'h0000_1388, 32'h0000_0000};

   // 10 MHz sample clock
   always #50 clk = ~clk;

   trs_sequencer u_trs_sequencer (.clk(clk), .resetn(resetn),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .button_pin(button_pin), .ext_trig_pin(ext_trig_pin),
      .pass_done(pass_done), .play(play));
   trs_engine_model #(.LEN(LEN)) u_trs_engine_model (.clk(clk),
      .resetn(resetn), .play(play), .pass_done(pass_done));

   // Count pass starts
   always @(posedge clk) begin
      if (play.start === 1'b1) n_start++;
   end

   // Burst readback: zero becomes one, excess clips to the maximum
   function automatic logic [31:0] burst_exp(input logic [31:0] v);
      if (v == 32'h0000_0000) return 32'h0000_0001;
      if (v > 32'h0000_1000) return 32'h0000_1000;
      return v;
   endfunction

   // Strobe edge to start: host pulse, load, delay count, pipeline
   function automatic int lat_exp(input int dl);
      return dl + trs_pkg::TRS_PIPE_CLKS + 2;
   endfunction

   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   // Bounded wait for a start pulse; kk counts edges waited
   task automatic wait_start(input int mx, output int kk);
      kk = 0;
      do begin
         @(posedge clk);
         #1;
         kk++;
      end while (play.start !== 1'b1 && kk < mx);
      `CHK("start_seen", 1'b1, play.start)
   endtask

   // Bounded wait for playback to stop
   task automatic wait_idle(input int mx);
      for (int i = 0; i < mx && play.active !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK("idle_seen", 1'b0, play.active)
   endtask

   task automatic finish_test();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Watchdog: the tests need far fewer than 10000 clocks
   initial begin
      #1_000_000;
      fails++;
      finish_test();
   end

   initial begin
      void'($urandom(32'h8ab8dd2b));
      d_tab[3] = $urandom_range(1, 4095);
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      // Reset values, write-only and unmapped places
      rd_reg(trs_pkg::TRS_OFF_CTRL, rv);
      `CHK("ctrl", 32'h0000_0000, rv)
      rd_reg(trs_pkg::TRS_OFF_DELAY, rv);
      `CHK("delay", 32'h0000_0000, rv)
      rd_reg(trs_pkg::TRS_OFF_CMD, rv);
      `CHK("cmd", 32'h0000_0000, rv)
      rd_reg(8'h14, rv);
      `CHK("unmapped", 32'h0000_0000, rv)
      wr_reg(trs_pkg::TRS_OFF_DELAY, 32'hFFFF_FFFF);
      rd_reg(trs_pkg::TRS_OFF_DELAY, rv);
      `CHK("delay_max", 32'hFFFF_FFFF, rv)
      rd_reg(trs_pkg::TRS_OFF_BURST, rv);
      `CHK("burst", 32'h0000_0001, rv)
      // Burst field edges plus one random legal count
      foreach (d_tab[i]) begin
         wr_reg(trs_pkg::TRS_OFF_BURST, d_tab[i]);
         rd_reg(trs_pkg::TRS_OFF_BURST, rv);
         `CHK("burst", burst_exp(d_tab[i]), rv)
      end
      $display("test regs done");

      // Continuous: repeats with no trigger
      n_start = 0;
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_0008);
      wait_start(4, k);
      repeat (5 * (LEN + 1)) @(posedge clk);
      `CHK("cont_runs", 1'b1, n_start >= 5)
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_0000);
      wait_idle(3);
      $display("test continuous done");

      // Single: latency per delay, extra trigger dropped
      wr_reg(trs_pkg::TRS_OFF_BURST, 32'h0000_0003);
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_0009);
      for (int i = 0; i < 3; i++) begin
         d = (i == 0) ? 0 : $urandom_range(1, 15);
         wr_reg(trs_pkg::TRS_OFF_DELAY, d);
         n_start = 0;
         wr_reg(trs_pkg::TRS_OFF_CMD, 32'h0000_0001);
         wait_start(40, k);
         `CHK("latency", lat_exp(d), k)
         wr_reg(trs_pkg::TRS_OFF_CMD, 32'h0000_0001);
         wait_idle(LEN + 8);
         repeat (30) @(posedge clk);
         `CHK("single_n", 1, n_start)
         rd_reg(trs_pkg::TRS_OFF_STATUS, rv);
         `CHK("missed", 1'b1, rv[trs_pkg::TRS_ST_MISS_BIT])
         wr_reg(trs_pkg::TRS_OFF_STATUS, 32'h0000_0004);
         rd_reg(trs_pkg::TRS_OFF_STATUS, rv);
         `CHK("miss_clr", 1'b0, rv[trs_pkg::TRS_ST_MISS_BIT])
      end
      $display("test single done");

      // Burst: random count, mid-burst trigger ignored
      n = $urandom_range(2, 4);
      wr_reg(trs_pkg::TRS_OFF_BURST, n);
      wr_reg(trs_pkg::TRS_OFF_DELAY, 32'h0000_0003);
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_000A);
      n_start = 0;
      wr_reg(trs_pkg::TRS_OFF_CMD, 32'h0000_0001);
      wait_start(40, k);
      `CHK("burst_lat", lat_exp(3), k)
      wr_reg(trs_pkg::TRS_OFF_CMD, 32'h0000_0001);
      rd_reg(trs_pkg::TRS_OFF_STATUS, rv);
      `CHK("playing", 1'b1, rv[trs_pkg::TRS_ST_PLAY_BIT])
      `CHK("left", n, rv[trs_pkg::TRS_ST_LEFT_LSB +: 13])
      wait_idle(n * (LEN + 3) + 10);
      repeat (30) @(posedge clk);
      `CHK("burst_n", n, n_start)
      $display("test burst done");

      // Pins: falling external edge, wrong edge, pushbutton
      wr_reg(trs_pkg::TRS_OFF_DELAY, 32'h0000_0000);
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_0005);
      ext_trig_pin <= 1'b1;
      repeat (8) @(posedge clk);
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_000D);
      n_start = 0;
      ext_trig_pin <= 1'b0;
      wait_start(20, k);
      wait_idle(LEN + 8);
      ext_trig_pin <= 1'b1;
      repeat (25) @(posedge clk);
      `CHK("pol_edge", 1, n_start)
      button_pin <= 1'b1;
      wait_start(20, k);
      button_pin <= 1'b0;
      wait_idle(LEN + 8);
      $display("test sources done");

      // Gated: gate opens, closes mid pass, pass completes
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_0003);
      ext_trig_pin <= 1'b0;
      repeat (8) @(posedge clk);
      wr_reg(trs_pkg::TRS_OFF_CTRL, 32'h0000_000B);
      ext_trig_pin <= 1'b1;
      wait_start(20, k);
      wait_start(LEN + 4, k);
      ext_trig_pin <= 1'b0;
      @(posedge clk);
      #1;
      n = n_start;
      repeat (LEN - 3) @(posedge clk);
      #1;
      `CHK("gate_tail", 1'b1, play.active)
      wait_idle(LEN);
      repeat (20) @(posedge clk);
      `CHK("gate_stop", n, n_start)
      $display("test gated done");
      finish_test();
   end
endmodule
